// File: rtl/wwdt_pkg.sv
// constants for the window watchdog and its supervisor sequencer
// assumes a 40 MHz clock and a 32-bit AXI4-Lite register bus
package wwdt_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETUP_TIME_US = 150;
  localparam int unsigned EVAL_TIME_US = 381;
  localparam int unsigned SETUP_CYC = (SETUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EVAL_CYC = (EVAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_UPPER = 8'h00;
  localparam logic [7:0] ADDR_RST_DELAY = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [31:0] UPPER_RESET = 32'h0001_0000;
  localparam logic [31:0] RST_DELAY_RESET = 32'h0000_8000;
  localparam int unsigned IRQ_EARLY = 0;
  localparam int unsigned IRQ_LATE = 1;
  localparam int unsigned IRQ_SUPV = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // modes, pin classes, states
  localparam logic [1:0] MODE_R34 = 2'h0;
  localparam logic [1:0] MODE_R18 = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h2;
  localparam logic [1:0] MODE_R12 = 2'h3;
  localparam logic [1:0] PIN_OPEN = 2'h0;
  localparam logic [1:0] PIN_PULLED = 2'h1;
  localparam logic [1:0] PIN_CAP = 2'h2;
  typedef enum logic [1:0] {
    SV_HOLD = 2'b00, SV_EVAL = 2'b01, SV_DELAY = 2'b10, SV_OK = 2'b11
  } wwdt_sv_state_type;
  typedef enum logic [2:0] {
    WD_OFF = 3'b000, WD_SETUP = 3'b001, WD_WAIT = 3'b010,
    WD_FIRST = 3'b011, WD_RUN = 3'b100, WD_FAULT = 3'b101
  } wwdt_wd_state_type;
endpackage : wwdt_pkg

// File: rtl/wwdt_top.sv
// window watchdog with supervisor reset sequencer and AXI4-Lite registers
// assumes pins synchronous to clk; analog comparators and pin classifiers outside
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top #(
  parameter int unsigned SETUP_CYC = wwdt_pkg::SETUP_CYC,
  parameter int unsigned EVAL_CYC = wwdt_pkg::EVAL_CYC,
  parameter logic [31:0] UP_OPEN_R34 = 32'h002191C0,
  parameter logic [31:0] UP_OPEN_R18 = 32'h0010C8E0,
  parameter logic [31:0] UP_OPEN_R12 = 32'h03D09000,
  parameter logic [31:0] UP_PULLED = 32'h0006B6C0,
  parameter logic [31:0] RST_OPEN = 32'h007A1200,
  parameter logic [31:0] RST_PULLED = 32'h00061A80
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic kick_input,
  input wire logic sense_in_window,
  input wire logic supply_above_lockout,
  input wire logic window_timing_pulled,
  input wire logic window_timing_loaded,
  input wire logic reset_delay_pulled,
  input wire logic reset_delay_loaded,
  output logic window_fault_n_out,
  output logic window_fault_n_oe,
  output logic supervisor_reset_n_out,
  output logic supervisor_reset_n_oe,
  output logic irq
);
  // ==========================================================
  // helpers
  function automatic logic [31:0] lower_of(input logic [31:0] up, input logic [1:0] mode);
    unique case (mode)
      wwdt_pkg::MODE_R18: lower_of = up >> 3;
      wwdt_pkg::MODE_R34: lower_of = up - (up >> 2);
      default: lower_of = up >> 1;
    endcase
  endfunction : lower_of

  function automatic logic [1:0] pin_class(input logic pulled, input logic loaded);
    pin_class = loaded ? wwdt_pkg::PIN_CAP : (pulled ? wwdt_pkg::PIN_PULLED : wwdt_pkg::PIN_OPEN);
  endfunction : pin_class

  // ==========================================================
  // supervisor sequencer
  wwdt_pkg::wwdt_sv_state_type sv_state, next_sv_state;
  logic [31:0] sv_cnt, next_sv_cnt;
  logic [1:0] wd_class, next_wd_class, rst_class, next_rst_class;
  logic [1:0] mode_lat, next_mode_lat;
  logic [31:0] reg_upper, next_reg_upper, reg_rst_delay, next_reg_rst_delay;
  logic [31:0] rst_delay;
  logic window_ok;
  logic [1:0] mode_live;

  assign window_ok = sense_in_window && supply_above_lockout;
  assign mode_live = {mode_select_a, mode_select_b};
  assign rst_delay = (rst_class == wwdt_pkg::PIN_CAP) ? reg_rst_delay :
                     (rst_class == wwdt_pkg::PIN_PULLED) ? RST_PULLED : RST_OPEN;

  always_comb begin
    next_sv_state = sv_state;
    next_sv_cnt = sv_cnt + 32'h1;
    next_wd_class = wd_class;
    next_rst_class = rst_class;
    next_mode_lat = mode_lat;
    // timing choice follows the pins outside SV_OK and while the latched mode is MODE_OFF
    if (sv_state != wwdt_pkg::SV_OK || mode_lat == wwdt_pkg::MODE_OFF) begin
      next_mode_lat = mode_live;
    end
    unique case (sv_state)
      wwdt_pkg::SV_HOLD: begin
        next_sv_cnt = 32'h0;
        if (window_ok) begin
          next_sv_state = wwdt_pkg::SV_EVAL;
        end
      end
      wwdt_pkg::SV_EVAL: begin
        if (sv_cnt >= EVAL_CYC - 1) begin
          next_wd_class = pin_class(window_timing_pulled, window_timing_loaded);
          next_rst_class = pin_class(reset_delay_pulled, reset_delay_loaded);
          next_sv_state = wwdt_pkg::SV_DELAY;
          next_sv_cnt = 32'h0;
        end
      end
      wwdt_pkg::SV_DELAY: begin
        if (sv_cnt >= rst_delay - 32'h1) begin
          next_sv_state = wwdt_pkg::SV_OK;
        end
      end
      wwdt_pkg::SV_OK: next_sv_cnt = 32'h0;
    endcase
    if (!window_ok) begin
      next_sv_state = wwdt_pkg::SV_HOLD;
      next_sv_cnt = 32'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sv_state <= wwdt_pkg::SV_HOLD;
      sv_cnt <= 32'h0;
      wd_class <= wwdt_pkg::PIN_OPEN;
      rst_class <= wwdt_pkg::PIN_OPEN;
      mode_lat <= wwdt_pkg::MODE_OFF;
    end else begin
      sv_state <= next_sv_state;
      sv_cnt <= next_sv_cnt;
      wd_class <= next_wd_class;
      rst_class <= next_rst_class;
      mode_lat <= next_mode_lat;
    end
  end

  // ==========================================================
  // window watchdog
  wwdt_pkg::wwdt_wd_state_type wd_state, next_wd_state;
  logic [31:0] wd_cnt, next_wd_cnt, upper, lower;
  logic kick_prev, kick_fall, wd_active, pend, next_pend, ev_early, ev_late;

  assign kick_fall = kick_prev && !kick_input;
  // window loss stops the watchdog in the same cycle the supervisor reset asserts
  assign wd_active = (sv_state == wwdt_pkg::SV_OK) && window_ok &&
                     (mode_live != wwdt_pkg::MODE_OFF);
  assign upper = (wd_class == wwdt_pkg::PIN_CAP) ? reg_upper :
                 (wd_class == wwdt_pkg::PIN_PULLED) ? UP_PULLED :
                 (mode_lat == wwdt_pkg::MODE_R18) ? UP_OPEN_R18 :
                 (mode_lat == wwdt_pkg::MODE_R12) ? UP_OPEN_R12 : UP_OPEN_R34;
  assign lower = lower_of(upper, mode_lat);

  always_comb begin
    next_wd_state = wd_state;
    next_wd_cnt = wd_cnt + 32'h1;
    next_pend = pend;
    ev_early = 1'b0;
    ev_late = 1'b0;
    unique case (wd_state)
      wwdt_pkg::WD_OFF: begin
        next_wd_cnt = 32'h0;
        next_wd_state = (pend && rst_class == wwdt_pkg::PIN_CAP) ?
                        wwdt_pkg::WD_WAIT : wwdt_pkg::WD_SETUP;
        next_pend = 1'b0;
      end
      wwdt_pkg::WD_SETUP: begin
        if (wd_cnt >= SETUP_CYC - 1) begin
          next_wd_state = wwdt_pkg::WD_FIRST;
          next_wd_cnt = 32'h0;
        end
      end
      wwdt_pkg::WD_WAIT: begin
        if (wd_cnt >= rst_delay - 32'h1) begin
          next_wd_state = wwdt_pkg::WD_FIRST;
          next_wd_cnt = 32'h0;
        end
      end
      wwdt_pkg::WD_FIRST: begin
        if (kick_fall) begin
          next_wd_state = wwdt_pkg::WD_RUN;
          next_wd_cnt = 32'h0;
        end else if (wd_cnt >= upper - 32'h1) begin
          next_wd_state = wwdt_pkg::WD_FAULT;
          ev_late = 1'b1;
          next_wd_cnt = 32'h0;
        end
      end
      wwdt_pkg::WD_RUN: begin
        if (kick_fall && wd_cnt < lower) begin
          next_wd_state = wwdt_pkg::WD_FAULT;
          ev_early = 1'b1;
          next_wd_cnt = 32'h0;
        end else if (kick_fall) begin
          next_wd_cnt = 32'h0;
        end else if (wd_cnt >= upper - 32'h1) begin
          next_wd_state = wwdt_pkg::WD_FAULT;
          ev_late = 1'b1;
          next_wd_cnt = 32'h0;
        end
      end
      wwdt_pkg::WD_FAULT: begin
        if (wd_cnt >= rst_delay - 32'h1) begin
          next_wd_state = wwdt_pkg::WD_FIRST;
          next_wd_cnt = 32'h0;
        end
      end
      default: next_wd_state = wwdt_pkg::WD_OFF;
    endcase
    if (!wd_active) begin
      next_wd_state = wwdt_pkg::WD_OFF;
      next_wd_cnt = 32'h0;
      ev_early = 1'b0;
      ev_late = 1'b0;
      // only a mode-pin disable during a fault is remembered
      next_pend = (sv_state == wwdt_pkg::SV_OK) &&
                  (pend || wd_state == wwdt_pkg::WD_FAULT);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_state <= wwdt_pkg::WD_OFF;
      wd_cnt <= 32'h0;
      pend <= 1'b0;
      kick_prev <= 1'b0;
      window_fault_n_oe <= 1'b0;
      supervisor_reset_n_oe <= 1'b1;
    end else begin
      wd_state <= next_wd_state;
      wd_cnt <= next_wd_cnt;
      pend <= next_pend;
      kick_prev <= kick_input;
      window_fault_n_oe <= (next_wd_state == wwdt_pkg::WD_FAULT);
      supervisor_reset_n_oe <= (next_sv_state != wwdt_pkg::SV_OK);
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      window_fault_n_out <= 1'b0;
      supervisor_reset_n_out <= 1'b0;
    end else begin
      window_fault_n_out <= 1'b0;
      supervisor_reset_n_out <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite slave and interrupt
  logic aw_got, next_aw_got, w_got, next_w_got, next_bvalid, next_rvalid, next_irq;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [2:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
  logic do_write;
  logic [31:0] status_word;

  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign status_word = {20'h0, pend, wd_state, rst_class, wd_class, mode_lat,
                        window_fault_n_oe, supervisor_reset_n_oe};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  always_comb begin
    next_aw_got = aw_got || (s_axi_awvalid && s_axi_awready);
    next_w_got = w_got || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_reg_upper = reg_upper;
    next_reg_rst_delay = reg_rst_delay;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wwdt_pkg::RESP_OKAY;
      unique case (aw_addr)
        wwdt_pkg::ADDR_UPPER: next_reg_upper = merge(reg_upper, w_data, w_strb);
        wwdt_pkg::ADDR_RST_DELAY: next_reg_rst_delay = merge(reg_rst_delay, w_data, w_strb);
        wwdt_pkg::ADDR_STATUS: ;
        wwdt_pkg::ADDR_IRQ_STATUS:
          next_irq_status = w_strb[0] ? (irq_status & ~w_data[2:0]) : irq_status;
        wwdt_pkg::ADDR_IRQ_MASK: next_irq_mask = w_strb[0] ? w_data[2:0] : irq_mask;
        default: next_bresp = wwdt_pkg::RESP_SLVERR;
      endcase
    end
    // events win over a clear in the same cycle
    next_irq_status[wwdt_pkg::IRQ_EARLY] = next_irq_status[wwdt_pkg::IRQ_EARLY] | ev_early;
    next_irq_status[wwdt_pkg::IRQ_LATE] = next_irq_status[wwdt_pkg::IRQ_LATE] | ev_late;
    next_irq_status[wwdt_pkg::IRQ_SUPV] = next_irq_status[wwdt_pkg::IRQ_SUPV] |
      (sv_state == wwdt_pkg::SV_OK && !window_ok);
    next_irq = |(next_irq_status & next_irq_mask);
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = wwdt_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        wwdt_pkg::ADDR_UPPER: next_rdata = reg_upper;
        wwdt_pkg::ADDR_RST_DELAY: next_rdata = reg_rst_delay;
        wwdt_pkg::ADDR_STATUS: next_rdata = status_word;
        wwdt_pkg::ADDR_IRQ_STATUS: next_rdata = {29'h0, irq_status};
        wwdt_pkg::ADDR_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = wwdt_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wwdt_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= wwdt_pkg::RESP_OKAY;
      reg_upper <= wwdt_pkg::UPPER_RESET;
      reg_rst_delay <= wwdt_pkg::RST_DELAY_RESET;
      irq_status <= 3'h0;
      irq_mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= !next_aw_got && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_w_got && !(s_axi_wvalid && s_axi_wready);
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      reg_upper <= next_reg_upper;
      reg_rst_delay <= next_reg_rst_delay;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_disable_release;
    (mode_live == wwdt_pkg::MODE_OFF) |=> !window_fault_n_oe;
  endproperty
  a_disable_release: assert property (p_disable_release) else $error("fault held while disabled");
  property p_supv_release;
    !window_ok |=> !window_fault_n_oe && supervisor_reset_n_oe;
  endproperty
  a_supv_release: assert property (p_supv_release) else $error("fault held in reset");
  property p_setup_ignore;
    (wd_state == wwdt_pkg::WD_SETUP) && wd_active |=> wd_state != wwdt_pkg::WD_RUN;
  endproperty
  a_setup_ignore: assert property (p_setup_ignore) else $error("kick taken in setup");
  property p_first_kick;
    (wd_state == wwdt_pkg::WD_FIRST) && kick_fall && wd_active |=> wd_state == wwdt_pkg::WD_RUN;
  endproperty
  a_first_kick: assert property (p_first_kick) else $error("first kick refused");
  property p_early;
    (wd_state == wwdt_pkg::WD_RUN) && kick_fall && wd_cnt < lower && wd_active
      |=> window_fault_n_oe && irq_status[wwdt_pkg::IRQ_EARLY];
  endproperty
  a_early: assert property (p_early) else $error("early kick missed");
  property p_in_window;
    (wd_state == wwdt_pkg::WD_RUN) && kick_fall && wd_cnt >= lower && wd_active
      |=> !window_fault_n_oe && wd_cnt == 32'h0;
  endproperty
  a_in_window: assert property (p_in_window) else $error("good kick faulted");
  property p_rising_ignored;
    (wd_state == wwdt_pkg::WD_RUN) && !kick_prev && kick_input && wd_active
      && wd_cnt < upper - 32'h1 |=> wd_cnt == $past(wd_cnt) + 32'h1;
  endproperty
  a_rising_ignored: assert property (p_rising_ignored) else $error("rising edge counted");
  property p_late;
    (wd_state == wwdt_pkg::WD_RUN) && !kick_fall && wd_cnt == upper - 32'h1 && wd_active
      |=> window_fault_n_oe;
  endproperty
  a_late: assert property (p_late) else $error("late kick missed");
  property p_eval;
    $rose(sv_state == wwdt_pkg::SV_EVAL) && window_ok |-> supervisor_reset_n_oe;
  endproperty
  a_eval: assert property (p_eval) else $error("reset released in eval");
endmodule : wwdt_top
`default_nettype wire

// File: tb/wwdt_host_model.sv
// host side model: drives the kick pin with falling edges at a set gap
// assumes run, gap and lvl change just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module wwdt_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [31:0] gap,
  input wire logic lvl,
  output logic kick
);
  // ==========================================================
  // kick pacing
  logic [31:0] cnt;
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt <= 32'h0;
      kick <= lvl;
    end else if (cnt >= gap - 32'h1) begin
      cnt <= 32'h0;
      kick <= 1'b0;
    end else begin
      cnt <= cnt + 32'h1;
      // short low pulse, only its fall matters
      if (cnt == 32'h2) kick <= 1'b1;
    end
  end
endmodule : wwdt_host_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the window watchdog
// assumes shortened timing parameters and pin classifiers reading open except in the capacitor-class part
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SU = 32'h14;
  localparam int EV = 32'h14;
  localparam int UP = 32'hC8;
  localparam int RD = 32'h32;
  localparam int U18 = 32'hA0;
  localparam int U12 = 32'hF0;
  localparam int UPP = 32'h78;
  localparam int RC = 32'h1E;
  localparam int LIMIT = 32'hEA60;
  logic clk, resetn, mode_select_a, mode_select_b, kick_input, sense_in_window;
  logic supply_above_lockout, run, lvl, last_pin, irq, window_fault_n_oe, supervisor_reset_n_oe;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, gap, rv;
  logic [3:0] s_axi_wstrb, cls;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic fo, so;
  int n_mismatch, checked, cyc, t_pin, n;
  wwdt_top #(.SETUP_CYC(SU), .EVAL_CYC(EV), .UP_OPEN_R34(UP), .UP_OPEN_R18(U18),
    .UP_OPEN_R12(U12), .UP_PULLED(UP), .RST_OPEN(RD), .RST_PULLED(RD)
  ) i_wwdt_top (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mode_select_a, .mode_select_b, .kick_input, .sense_in_window,
    .supply_above_lockout, .window_timing_pulled(cls[3]), .window_timing_loaded(cls[2]),
    .reset_delay_pulled(cls[1]), .reset_delay_loaded(cls[0]), .window_fault_n_out(fo),
    .window_fault_n_oe, .supervisor_reset_n_out(so), .supervisor_reset_n_oe, .irq);
  wwdt_host_model i_wwdt_host_model (.clk, .run, .gap, .lvl, .kick(kick_input));
  // ==========================================================
  // clock, timeout, verdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // compares
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : cmp_rng
  // ==========================================================
  // register bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // ==========================================================
  // pins and waits
  task automatic set_pin(input logic b_pin, input logic v);
    // other pin moved lately: keep the spacing
    while (b_pin != last_pin && cyc < t_pin + 32'h4E20) @(posedge clk);
    if (b_pin) mode_select_b <= v;
    else mode_select_a <= v;
    last_pin = b_pin;
    t_pin = cyc;
  endtask : set_pin
  task automatic wfault(input int mx);
    n = 0;
    while (window_fault_n_oe !== 1'b1 && n < mx) begin
      @(posedge clk);
      n++;
    end
  endtask : wfault
  task automatic whold();
    n = 0;
    while (window_fault_n_oe === 1'b1 && n < 32'h1F4) begin
      @(posedge clk);
      n++;
    end
  endtask : whold
  task automatic quiet(input int k);
    logic bad;
    bad = 1'b0;
    repeat (k) begin
      @(posedge clk);
      if (window_fault_n_oe !== 1'b0) bad = 1'b1;
    end
    cmp({31'h0, bad}, 32'h0);
  endtask : quiet
  task automatic wsup();
    n = 0;
    while (supervisor_reset_n_oe !== 1'b0 && n < 32'h190) begin
      @(posedge clk);
      n++;
    end
  endtask : wsup
  task automatic sv_event(input int d);
    sense_in_window <= 1'b0;
    repeat (32'h14) @(posedge clk);
    sense_in_window <= 1'b1;
    wsup();
    cmp_rng(n, EV + d - 1, EV + d + 3);
  endtask : sv_event
  // ==========================================================
  // main sequence
  initial begin
    {n_mismatch, checked, cyc, t_pin} = '0;
    {resetn, last_pin, mode_select_b, sense_in_window, run, cls} = '0;
    {mode_select_a, supply_above_lockout, lvl} = 3'h7;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    gap = 32'hAA;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (32'h1E) @(posedge clk);
    cmp({31'h0, supervisor_reset_n_oe}, 32'h1);
    sense_in_window <= 1'b1;
    wsup();
    cmp_rng(n, EV + RD - 1, EV + RD + 3);
    rd(wwdt_pkg::ADDR_UPPER);
    cmp(rv, wwdt_pkg::UPPER_RESET);
    rd(wwdt_pkg::ADDR_RST_DELAY);
    cmp(rv, wwdt_pkg::RST_DELAY_RESET);
    rd(8'h14);
    cmp({30'h0, rr}, {30'h0, wwdt_pkg::RESP_SLVERR});
    cmp(rv, 32'h0);
    wr(8'h14, 32'h0);
    cmp({30'h0, br}, {30'h0, wwdt_pkg::RESP_SLVERR});
    wr(wwdt_pkg::ADDR_IRQ_MASK, 32'h7);
    cmp({30'h0, br}, {30'h0, wwdt_pkg::RESP_OKAY});
    rd(wwdt_pkg::ADDR_IRQ_MASK);
    cmp(rv, 32'h7);
    wr(wwdt_pkg::ADDR_IRQ_STATUS, 32'h7);
    run <= 1'b1;
    set_pin(1'b0, 1'b0);
    quiet(32'h3E8);
    gap <= 32'h64;
    wfault(32'h258);
    cmp({31'h0, window_fault_n_oe}, 32'h1);
    whold();
    cmp_rng(n, RD - 1, RD + 1);
    run <= 1'b0;
    cmp({31'h0, irq}, 32'h1);
    rd(wwdt_pkg::ADDR_IRQ_STATUS);
    cmp(rv, 32'h1);
    wr(wwdt_pkg::ADDR_IRQ_STATUS, 32'h1);
    rd(wwdt_pkg::ADDR_IRQ_STATUS);
    cmp(rv, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wfault(32'h190);
    cmp({31'h0, window_fault_n_oe}, 32'h1);
    set_pin(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    cmp({31'h0, window_fault_n_oe}, 32'h0);
    quiet(32'h190);
    wr(wwdt_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    set_pin(1'b0, 1'b0);
    repeat (32'hA) @(posedge clk);
    lvl <= 1'b0;
    repeat (32'h5A) @(posedge clk);
    lvl <= 1'b1;
    wfault(32'h190);
    cmp_rng(n + 32'h64, SU + UP - 2, SU + UP + 4);
    whold();
    cmp_rng(n, RD - 1, RD + 1);
    // capacitor classes: both timeouts come from the registers
    wr(wwdt_pkg::ADDR_UPPER, UPP);
    wr(wwdt_pkg::ADDR_RST_DELAY, RC);
    cls <= 4'hF;
    sv_event(RC);
    wfault(32'h190);
    cmp_rng(n, SU + UPP - 2, SU + UPP + 2);
    set_pin(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    set_pin(1'b0, 1'b0);
    wfault(32'h190);
    cmp_rng(n, RC + UPP - 2, RC + UPP + 2);
    whold();
    cmp_rng(n, RC - 1, RC + 1);
    cls <= 4'h0;
    sv_event(RD);
    gap <= 32'hAA;
    run <= 1'b1;
    set_pin(1'b1, 1'b1);
    quiet(32'h3E8);
    sv_event(RD);
    wfault(32'h258);
    cmp({31'h0, window_fault_n_oe}, 32'h1);
    sense_in_window <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({window_fault_n_oe, supervisor_reset_n_oe}, 2'h1);
    cmp({30'h0, fo, so}, 32'h0);
    gap <= 32'h28;
    quiet(32'h12C);
    sense_in_window <= 1'b1;
    wsup();
    quiet(32'h3E8);
    set_pin(1'b0, 1'b1);
    sv_event(RD);
    wfault(32'h258);
    cmp({31'h0, window_fault_n_oe}, 32'h1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
